// ===== logic/otg_vbus_control_status.sv
// The address map and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "otg_supply_defines.svh"

module otg_vbus_control_status (
	input  wire logic                        clk,
	input  wire logic                        nrst,
	input  wire logic                        active_low_reset_pin,
	input  wire logic                        cmp_session_end_raw,
	input  wire logic                        cmp_session_valid_raw,
	input  wire logic                        cmp_supply_valid_raw,
	input  wire logic [1:0]                  line_state_in,
	output logic      [1:0]                  line_state_out,
	output logic                             rxcmd_supply_valid,
	output otg_supply_pkg::analog_ctl_t      analog_ctl,
	output logic                             irq,
	input  wire logic [7:0]                  s_axi_awaddr,
	input  wire logic                        s_axi_awvalid,
	output logic                             s_axi_awready,
	input  wire logic [31:0]                 s_axi_wdata,
	input  wire logic [3:0]                  s_axi_wstrb,
	input  wire logic                        s_axi_wvalid,
	output logic                             s_axi_wready,
	output logic [1:0]                       s_axi_bresp,
	output logic                             s_axi_bvalid,
	input  wire logic                        s_axi_bready,
	input  wire logic [7:0]                  s_axi_araddr,
	input  wire logic                        s_axi_arvalid,
	output logic                             s_axi_arready,
	output logic [31:0]                      s_axi_rdata,
	output logic [1:0]                       s_axi_rresp,
	output logic                             s_axi_rvalid,
	input  wire logic                        s_axi_rready
);
	logic       rst_meta_ff;
	logic       rst_sync_ff;
	logic       rst_n;
	logic       pin_meta_ff;
	logic       pin_sync_ff;
	logic [7:0] otg_ctrl_ff;
	logic [3:0] rise_en_ff;
	logic [3:0] fall_en_ff;
	logic [3:0] irq_stat_ff;
	logic [3:0] irq_mask_ff;
	logic [2:0] ext_ind_ff;
	logic [7:0] io_pwr_ff;
	logic [7:0] aw_addr_ff;
	logic [31:0] w_data_ff;
	logic [3:0] w_strb_ff;
	logic       aw_have_ff;
	logic       w_have_ff;
	logic       bvalid_ff;
	logic [1:0] bresp_ff;
	logic       rvalid_ff;
	logic [31:0] rdata_ff;
	logic [1:0] rresp_ff;
	logic [1:0] line_ff;
	logic [1:0] rsync_a_ff;
	logic [1:0] rsync_b_ff;
	logic       reg_rst_n;

	// reset release through two flops
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rst_meta_ff <= 1'b0;
			rst_sync_ff <= 1'b0;
		end else begin
			rst_meta_ff <= 1'b1;
			rst_sync_ff <= rst_meta_ff;
		end
	end
	// everything else resets from this copy, so release never lands mid-cycle
	assign rst_n = rst_sync_ff;

	// reset pin is outside our domain; synchronise it like any pin
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_meta_ff <= 1'b0;
			pin_sync_ff <= 1'b0;
		end else begin
			pin_meta_ff <= active_low_reset_pin;
			pin_sync_ff <= pin_meta_ff;
		end
	end

	// raw line state also arrives from the pads
	// both bits share one synchroniser so they never disagree by a cycle
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rsync_a_ff <= 2'b00;
			rsync_b_ff <= 2'b00;
		end else begin
			rsync_a_ff <= line_state_in;
			rsync_b_ff <= rsync_a_ff;
		end
	end
	assign reg_rst_n = rst_n;

	// ---------------- comparator enables and edges ----------------
	wire [3:0] cmp_raw = {cmp_session_end_raw, cmp_session_valid_raw, cmp_supply_valid_raw, 1'b0};
	wire [3:0] both_off = ~(rise_en_ff | fall_en_ff);
	wire [3:0] cmp_en;
	wire [3:0] cmp_live;
	wire [3:0] cmp_evt;

	assign cmp_en[`CMP_SESSION_END] = ~both_off[`CMP_SESSION_END];
	assign cmp_en[`CMP_SESSION_VALID] = 1'b1;
	assign cmp_en[`CMP_SUPPLY_VALID] = ~both_off[`CMP_SUPPLY_VALID];
	assign cmp_en[0] = 1'b0;

	cmp_edge_detect #(
		.WIDTH (4)
	) u_edges (
		.clk      (clk),
		.rst_n    (rst_n),
		.raw_in   (cmp_raw),
		.cmp_en   (cmp_en),
		.rise_en  (rise_en_ff),
		.fall_en  (fall_en_ff),
		.live     (cmp_live),
		.edge_evt (cmp_evt)
	);

	// ---------------- bus decode ----------------
	wire do_write = aw_have_ff & w_have_ff & ~bvalid_ff;
	wire wr_hit_otg   = do_write && aw_addr_ff == `REG_OTG_CTRL;
	wire wr_hit_rise  = do_write && aw_addr_ff == `REG_EDGE_RISE_EN;
	wire wr_hit_fall  = do_write && aw_addr_ff == `REG_EDGE_FALL_EN;
	wire wr_hit_stat  = do_write && aw_addr_ff == `REG_IRQ_STATUS;
	wire wr_hit_mask  = do_write && aw_addr_ff == `REG_IRQ_MASK;
	wire wr_hit_ext   = do_write && aw_addr_ff == `REG_EXT_IND_CTRL;
	wire wr_hit_iop   = do_write && aw_addr_ff == `REG_IO_PWR;
	// writes to the read-only words are accepted and dropped
	wire wr_known     = wr_hit_otg | wr_hit_rise | wr_hit_fall | wr_hit_stat |
	                    wr_hit_mask | wr_hit_ext | wr_hit_iop |
	                    (aw_addr_ff == `REG_LIVE_STATUS) | (aw_addr_ff == `REG_SUPPLY_FLAGS);
	wire wr_lane0     = w_strb_ff[0];
	wire [7:0] wbyte  = w_data_ff[7:0];

	assign s_axi_awready = ~aw_have_ff;
	assign s_axi_wready  = ~w_have_ff;
	assign s_axi_bvalid  = bvalid_ff;
	assign s_axi_bresp   = bresp_ff;
	assign s_axi_arready = ~rvalid_ff;
	assign s_axi_rvalid  = rvalid_ff;
	assign s_axi_rdata   = rdata_ff;
	assign s_axi_rresp   = rresp_ff;

	// write channel capture, either order
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			aw_have_ff <= 1'b0;
			w_have_ff  <= 1'b0;
			aw_addr_ff <= 8'h00;
			w_data_ff  <= 32'h0000_0000;
			w_strb_ff  <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_ff <= 1'b1;
				aw_addr_ff <= {s_axi_awaddr[7:2], 2'b00};
			end else if (do_write) begin
				aw_have_ff <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_ff <= 1'b1;
				w_data_ff <= s_axi_wdata;
				w_strb_ff <= s_axi_wstrb;
			end else if (do_write) begin
				w_have_ff <= 1'b0;
			end
		end
	end

	// write response; unmapped addresses answer slverr
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bvalid_ff <= 1'b0;
			bresp_ff  <= 2'b00;
		end else if (do_write) begin
			bvalid_ff <= 1'b1;
			bresp_ff  <= wr_known ? 2'b00 : 2'b10;
		end else if (s_axi_bready) begin
			bvalid_ff <= 1'b0;
		end
	end

	// ---------------- control registers ----------------
	// external drive cleared at reset
	always_ff @(posedge clk or negedge reg_rst_n) begin
		if (!reg_rst_n) begin
			otg_ctrl_ff <= `OTG_CTRL_RESET;
			rise_en_ff  <= `EDGE_EN_RESET;
			fall_en_ff  <= `EDGE_EN_RESET;
			irq_mask_ff <= `IRQ_MASK_RESET;
			ext_ind_ff  <= `EXT_IND_RESET;
			io_pwr_ff   <= `IO_PWR_RESET;
		end else if (wr_lane0) begin
			if (wr_hit_otg)  otg_ctrl_ff <= wbyte;
			if (wr_hit_rise) rise_en_ff  <= {wbyte[3:1], 1'b0};
			if (wr_hit_fall) fall_en_ff  <= {wbyte[3:1], 1'b0};
			if (wr_hit_mask) irq_mask_ff <= {wbyte[3:1], 1'b0};
			if (wr_hit_ext)  ext_ind_ff  <= wbyte[2:0];
			if (wr_hit_iop)  io_pwr_ff   <= wbyte;
		end
	end

	// edge events are sticky; a new event beats a clear
	wire [3:0] stat_clr = (wr_hit_stat && wr_lane0) ? wbyte[3:0] : 4'h0;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_stat_ff <= 4'h0;
		end else begin
			irq_stat_ff <= (irq_stat_ff & ~stat_clr) | cmp_evt;
		end
	end
	assign irq = |(irq_stat_ff & irq_mask_ff);

	// ---------------- read path ----------------
	wire [3:0] flags_view = cmp_live;
	wire [31:0] rd_mux =
		(s_axi_araddr[7:2] == `REG_OTG_CTRL     >> 2) ? {24'h000000, otg_ctrl_ff} :
		(s_axi_araddr[7:2] == `REG_EDGE_RISE_EN >> 2) ? {28'h0000000, rise_en_ff} :
		(s_axi_araddr[7:2] == `REG_EDGE_FALL_EN >> 2) ? {28'h0000000, fall_en_ff} :
		(s_axi_araddr[7:2] == `REG_LIVE_STATUS  >> 2) ? {28'h0000000, flags_view} :
		(s_axi_araddr[7:2] == `REG_IRQ_STATUS   >> 2) ? {28'h0000000, irq_stat_ff} :
		(s_axi_araddr[7:2] == `REG_IRQ_MASK     >> 2) ? {28'h0000000, irq_mask_ff} :
		(s_axi_araddr[7:2] == `REG_EXT_IND_CTRL >> 2) ? {29'h00000000, ext_ind_ff} :
		(s_axi_araddr[7:2] == `REG_IO_PWR       >> 2) ? {24'h000000, io_pwr_ff} :
		{30'h00000000, rxcmd_supply_valid, analog_ctl.ext_supply_enable_out};
	// low address bits are ignored; anything past the last word answers slverr
	wire rd_known = s_axi_araddr[7:2] <= (`REG_SUPPLY_FLAGS >> 2);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rvalid_ff <= 1'b0;
			rdata_ff  <= 32'h0000_0000;
			rresp_ff  <= 2'b00;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rvalid_ff <= 1'b1;
			rdata_ff  <= rd_known ? rd_mux : 32'h0000_0000;
			rresp_ff  <= rd_known ? 2'b00 : 2'b10;
		end else if (s_axi_rready) begin
			rvalid_ff <= 1'b0;
		end
	end

	// ---------------- external indicator select ----------------
	// indicator tied high; selector off by default
	wire ext_indicator = 1'b1;
	wire use_ext = ext_ind_ff[`EXT_USE_BIT];
	wire pass    = ext_ind_ff[`EXT_PASS_BIT];
	wire inv     = ext_ind_ff[`EXT_INV_BIT];
	wire sv_int  = cmp_live[`CMP_SUPPLY_VALID];
	assign rxcmd_supply_valid = !use_ext ? sv_int :
	                            pass     ? (ext_indicator ^ inv) :
	                            (inv ? 1'b0 : sv_int);

	// ---------------- analog controls ----------------
	wire serial_mode = io_pwr_ff[`IOP_SERIAL_MODE_BIT];
	assign analog_ctl.supply_discharge_ctl = otg_ctrl_ff[`OTG_DISCHARGE_BIT];
	assign analog_ctl.supply_charge_ctl = otg_ctrl_ff[`OTG_CHARGE_BIT];
	assign analog_ctl.ext_supply_enable_out = otg_ctrl_ff[`OTG_DRIVE_BIT] | otg_ctrl_ff[`OTG_DRIVE_EXT_BIT];
	assign analog_ctl.regulator_serial_sel = serial_mode;
	assign analog_ctl.serial_mode_regulator_level = io_pwr_ff[`IOP_REG_LEVEL_LSB +: 2];
	assign analog_ctl.charger_pullup_dplus_en  = pin_sync_ff & io_pwr_ff[`IOP_DP_PULLUP_BIT];
	assign analog_ctl.charger_pullup_dminus_en = pin_sync_ff & io_pwr_ff[`IOP_DM_PULLUP_BIT];

	// line state blanked in serial mode
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			line_ff <= 2'b00;
		end else begin
			line_ff <= serial_mode ? 2'b00 : rsync_b_ff;
		end
	end
	assign line_state_out = line_ff;
endmodule : otg_vbus_control_status

// ===== inc/otg_supply_defines.svh
`ifndef OTG_SUPPLY_DEFINES_SVH
`define OTG_SUPPLY_DEFINES_SVH

// register byte offsets on the bus
`define REG_OTG_CTRL        8'h00
`define REG_EDGE_RISE_EN    8'h04
`define REG_EDGE_FALL_EN    8'h08
`define REG_LIVE_STATUS     8'h0C
`define REG_IRQ_STATUS      8'h10
`define REG_IRQ_MASK        8'h14
`define REG_EXT_IND_CTRL    8'h18
`define REG_IO_PWR          8'h1C
`define REG_SUPPLY_FLAGS    8'h20

// otg control bit positions
`define OTG_DRIVE_BIT       5
`define OTG_DRIVE_EXT_BIT   6
`define OTG_DISCHARGE_BIT   3
`define OTG_CHARGE_BIT      4

// comparator bit positions in enables and status
`define CMP_SUPPLY_VALID    1
`define CMP_SESSION_VALID   2
`define CMP_SESSION_END     3

// external indicator control bits
`define EXT_USE_BIT         0
`define EXT_PASS_BIT        1
`define EXT_INV_BIT         2

// io and power bits
`define IOP_SERIAL_MODE_BIT 0
`define IOP_DP_PULLUP_BIT   1
`define IOP_DM_PULLUP_BIT   2
`define IOP_REG_LEVEL_LSB   4

// reset values
`define OTG_CTRL_RESET      8'h00
`define EDGE_EN_RESET       4'hE
`define EXT_IND_RESET       3'h0
`define IO_PWR_RESET        8'h00
`define IRQ_MASK_RESET      4'h0

`endif

// ===== inc/otg_supply_pkg.sv
package otg_supply_pkg;

	// one bit per comparator: [3] session end, [2] session valid, [1] supply valid
	typedef struct packed {
		logic session_end_flag;
		logic session_valid_flag;
		logic supply_valid_flag;
		logic spare;
	} cmp_flags_t;

	typedef struct packed {
		logic [1:0] serial_mode_regulator_level;
		logic       regulator_serial_sel;
		logic       supply_discharge_ctl;
		logic       supply_charge_ctl;
		logic       ext_supply_enable_out;
		logic       charger_pullup_dplus_en;
		logic       charger_pullup_dminus_en;
	} analog_ctl_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_RESP = 3'b010,
		ST_DONE = 3'b100
	} bus_state_t;

endpackage : otg_supply_pkg

// ===== logic/cmp_edge_detect.sv
`timescale 1ns/1ps
`include "otg_supply_defines.svh"

// synchronises the raw comparator outputs and flags enabled edges
module cmp_edge_detect #(
	parameter int WIDTH = 4
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic [WIDTH-1:0] raw_in,
	input  wire logic [WIDTH-1:0] cmp_en,
	input  wire logic [WIDTH-1:0] rise_en,
	input  wire logic [WIDTH-1:0] fall_en,
	output logic      [WIDTH-1:0] live,
	output logic      [WIDTH-1:0] edge_evt
);
	logic [WIDTH-1:0] meta_ff;
	logic [WIDTH-1:0] sync_ff;
	logic [WIDTH-1:0] prev_ff;
	logic [1:0]       fill_ff;
	// edges wait until the history holds real levels, else a level already high at reset looks like a rise
	wire              primed = (fill_ff == 2'h3);

	// comparators are asynchronous to clk, so two flops first
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_ff <= '0;
			sync_ff <= '0;
			prev_ff <= '0;
			fill_ff <= 2'h0;
		end else begin
			meta_ff <= raw_in;
			sync_ff <= meta_ff;
			prev_ff <= live;
			if (!primed) fill_ff <= fill_ff + 2'h1;
		end
	end

	// per comparator: gated live value and edge events
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_cmp
			assign live[i]     = sync_ff[i] & cmp_en[i];
			assign edge_evt[i] = primed & ((rise_en[i] & live[i] & ~prev_ff[i]) |
			                               (fall_en[i] & ~live[i] & prev_ff[i]));
		end
	endgenerate
endmodule : cmp_edge_detect

// ===== test/otg_vbus_control_status_props.sv
`timescale 1ns/1ps
// watches outputs against their causes at the pins
module otg_vbus_control_status_props (
	input wire logic                        clk,
	input wire logic                        nrst,
	input wire logic                        active_low_reset_pin,
	input wire logic [1:0]                  line_state_in,
	input wire logic [1:0]                  line_state_out,
	input wire otg_supply_pkg::analog_ctl_t analog_ctl,
	input wire logic                        s_axi_arready,
	input wire logic                        s_axi_bvalid,
	input wire logic                        s_axi_bready,
	input wire logic                        s_axi_rvalid,
	input wire logic                        s_axi_rready,
	input wire logic [31:0]                 s_axi_rdata,
	input wire logic [1:0]                  s_axi_rresp
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	// pin synchroniser is two deep, so the third low sample must force the pull-ups off
	pin_low_off_a: assert property (!active_low_reset_pin [*3] |-> !analog_ctl.charger_pullup_dplus_en
		&& !analog_ctl.charger_pullup_dminus_en) else $error("pull-up on while reset pin low");
	serial_ls_a: assert property (analog_ctl.regulator_serial_sel |=> line_state_out == 2'h0)
		else $error("line state shown in serial mode");
	// two synchroniser flops plus the output register: three cycles from pin to port
	ls_pass_a: assert property (!analog_ctl.regulator_serial_sel [*2] |-> line_state_out == $past(line_state_in, 3))
		else $error("line state not passed");
	ext_off_a: assert property ($rose(nrst) |-> !analog_ctl.ext_supply_enable_out)
		else $error("supply enable high out of reset");
	bhold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");
	rhold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer changed");
	rresp_legal_a: assert property (s_axi_rvalid |-> s_axi_rresp inside {2'h0, 2'h2}) else $error("bad rresp");
	ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("arready while rvalid");
	cover property (analog_ctl.regulator_serial_sel);
	cover property (!active_low_reset_pin [*3]);
	cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule : otg_vbus_control_status_props

bind otg_vbus_control_status otg_vbus_control_status_props otg_vbus_control_status_props_i (.clk(clk), .nrst(nrst),
	.active_low_reset_pin(active_low_reset_pin), .line_state_in(line_state_in), .line_state_out(line_state_out),
	.analog_ctl(analog_ctl), .s_axi_arready(s_axi_arready), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp));

// ===== test/link_model.sv
`timescale 1ns/1ps
// link side register master; each wait is bounded and reports through ok
module link_model (
	input  wire logic        clk,
	output logic      [7:0]  awaddr,
	output logic             awvalid,
	input  wire logic        awready,
	output logic      [31:0] wdata,
	output logic             wvalid,
	input  wire logic        wready,
	input  wire logic        bvalid,
	output logic             bready,
	output logic      [7:0]  araddr,
	output logic             arvalid,
	input  wire logic        arready,
	input  wire logic [31:0] rdata,
	input  wire logic [1:0]  rresp,
	input  wire logic        rvalid,
	output logic             rready
);
	initial begin
		{awaddr, awvalid, wdata, wvalid, bready, araddr, arvalid, rready} = '0;
	end
	// address and data offered together, each released at its own handshake
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output bit ok);
		int n;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		bready <= 1'b0;
		ok = n < 50;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r, output bit ok);
		int n;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge clk);
			if (arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		d = rdata;
		r = rresp;
		rready <= 1'b0;
		ok = n < 50;
	endtask : rd
endmodule : link_model

// ===== test/otg_vbus_control_status_test.sv
`timescale 1ns/1ps
module otg_vbus_control_status_test;
	logic                        clk, nrst, pin, se_raw, sv_raw, vv_raw, rxv, irq;
	logic [1:0]                  ls_in, ls_out, bresp, rresp;
	otg_supply_pkg::analog_ctl_t actl;
	logic [7:0]                  awaddr, araddr;
	logic [31:0]                 wdata, rdata;
	logic                        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	int                          n_errors, checks_done, i;
	logic [3:0]                  ext_sel [5] = '{4'h0, 4'h1, 4'h3, 4'h7, 4'h5};
	logic [7:0]                  rst_addr [6] = '{8'h00, 8'h04, 8'h08, 8'h14, 8'h18, 8'h1C};
	logic [31:0]                 rst_val [6] = '{32'h0, 32'hE, 32'hE, 32'h0, 32'h0, 32'h0};
	otg_vbus_control_status otg_vbus_control_status_i (.clk(clk), .nrst(nrst), .active_low_reset_pin(pin),
		.cmp_session_end_raw(se_raw), .cmp_session_valid_raw(sv_raw), .cmp_supply_valid_raw(vv_raw),
		.line_state_in(ls_in), .line_state_out(ls_out), .rxcmd_supply_valid(rxv), .analog_ctl(actl), .irq(irq),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
	link_model link_model_i (.clk(clk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
		.wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	task automatic finish_test();
		$display("errors %0d checks %0d", n_errors, checks_done);
		if (n_errors == 0 && checks_done > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : finish_test
	task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
		checks_done++;
		if (g !== e) begin
			n_errors++;
			$display("wrong value at %0t: %s got %h", $time, m, g);
		end
	endtask : chk
	task automatic wrt(input logic [7:0] a, input logic [31:0] d);
		bit ok;
		link_model_i.wr(a, d, ok);
		chk({ok, bresp}, {1'b1, 2'h0}, "write answer");
		if (!ok) finish_test();
	endtask : wrt
	// read one word; compare the response, and the data only when an okay response is expected
	task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		bit ok;
		logic [31:0] d;
		logic [1:0] r;
		link_model_i.rd(a, d, r, ok);
		chk(ok, 1'b1, "read answer timed out");
		if (!ok) finish_test();
		chk(r, er, "read response");
		if (er == 2'h0) chk(d, e, "read data");
	endtask : rdc
	// comparator changes settle after the two-flop synchroniser plus event stage
	task automatic settle();
		repeat (5) @(posedge clk);
	endtask : settle
	initial begin
		{nrst, pin, se_raw, sv_raw, vv_raw, ls_in, n_errors, checks_done} = '0;
		repeat (20) @(posedge clk);
		nrst <= 1'b1;
		pin <= 1'b1;
		repeat (4) @(posedge clk);
		for (i = 0; i < 6; i++) rdc(rst_addr[i], rst_val[i], 2'h0);
		chk(actl.ext_supply_enable_out, 1'b0, "supply enable at reset");
		rdc(8'h40, 32'h0, 2'h2);
		$display("test reset values done");
		// each drive bit alone, then both together
		for (i = 3; i < 8; i++) begin
			wrt(8'h00, (i == 7) ? 32'h60 : (32'h1 << i));
			chk(actl.supply_discharge_ctl, i == 3, "discharge");
			chk(actl.supply_charge_ctl, i == 4, "charge");
			chk(actl.ext_supply_enable_out, i > 4, "supply enable or");
		end
		rdc(8'h20, {31'h0, 1'b1}, 2'h0);
		wrt(8'h00, 32'h0);
		$display("test otg control done");
		// each selector setting against both comparator levels
		for (i = 0; i < 10; i++) begin
			vv_raw <= i[0];
			wrt(8'h18, {28'h0, ext_sel[i / 2]});
			settle();
			chk(rxv, ext_sel[i / 2][0] ? (ext_sel[i / 2][1] ? !ext_sel[i / 2][2] : i[0] & !ext_sel[i / 2][2]) : i[0], "rxcmd");
		end
		$display("test indicator select done");
		wrt(8'h14, 32'hE);
		se_raw <= 1'b1;
		sv_raw <= 1'b1;
		settle();
		// presence taken from the session valid bit
		rdc(8'h0C, 32'hE, 2'h0);
		chk(irq, 1'b1, "irq on events");
		wrt(8'h10, 32'hE);
		chk(irq, 1'b0, "irq after clear");
		wrt(8'h04, 32'h0);
		wrt(8'h08, 32'h0);
		wrt(8'h10, 32'hE);
		sv_raw <= 1'b0;
		settle();
		sv_raw <= 1'b1;
		settle();
		rdc(8'h0C, 32'h4, 2'h0);
		chk(irq, 1'b0, "no irq when disabled");
		$display("test comparators done");
		ls_in <= 2'h3;
		wrt(8'h1C, 32'h36);
		chk({actl.serial_mode_regulator_level, actl.charger_pullup_dplus_en, actl.charger_pullup_dminus_en, ls_out}, 6'h3F, "pullups");
		pin <= 1'b0;
		settle();
		chk({actl.charger_pullup_dplus_en, actl.charger_pullup_dminus_en}, 2'h0, "pin low");
		pin <= 1'b1;
		wrt(8'h1C, 32'h27);
		@(posedge clk);
		chk({actl.serial_mode_regulator_level, actl.regulator_serial_sel, ls_out}, 5'h14, "serial mode");
		$display("test serial and pullups done");
		finish_test();
	end
endmodule : otg_vbus_control_status_test
